//--- lbm_pkg.sv
package lbm_pkg;

    // ------------------------------------------------------------
    // clock and cycle timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ         = 40_000_000;
    localparam int unsigned BUCKET_CYCLE_MS = 128;
    localparam int unsigned BUCKET_CYCLE_CLKS =
        (BUCKET_CYCLE_MS * (CLK_HZ / 1000));

    // ------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [7:0] IDX_UPPER  = 8'h58;
    localparam logic [7:0] IDX_LOWER  = 8'h59;
    localparam logic [7:0] IDX_CAP    = 8'h5A;
    localparam logic [7:0] IDX_DECAY  = 8'h5B;
    localparam logic [7:0] IDX_STATUS = 8'h60;
    localparam logic [7:0] IDX_MASK   = 8'h61;
    localparam logic [7:0] IDX_ACC    = 8'h62;
    localparam logic [7:0] IDX_FLAGS  = 8'h63;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_UPPER = 8'h06;
    localparam logic [7:0] RST_LOWER = 8'h04;
    localparam logic [7:0] RST_CAP   = 8'h08;
    localparam logic [1:0] RST_DECAY = 2'h1;
    localparam logic [2:0] RST_MASK  = 3'h0;

    // ------------------------------------------------------------
    // status bit positions
    // ------------------------------------------------------------
    localparam int unsigned ST_RAISE = 0;
    localparam int unsigned ST_CLEAR = 1;
    localparam int unsigned ST_SAT   = 2;
    localparam int unsigned ST_W     = 3;

    localparam int unsigned ADDR_W = 10;
    localparam int unsigned DATA_W = 32;

    typedef enum logic [0:0]
    {
        BUS_IDLE = 1'b0,
        BUS_ACK  = 1'b1
    } lbm_bus_t;

endpackage : lbm_pkg

//--- lbm_sync.sv
module lbm_sync #(
    parameter int unsigned WIDTH = 2
) (
    input  wire logic             clk_i,
    input  wire logic             reset_i,
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] level_o
);
    import lbm_pkg::*;

    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] lvl;
    } lbm_sync_st_t;

    lbm_sync_st_t     st_q;
    lbm_sync_st_t     st_d;
    logic [WIDTH-1:0] lvl_n;

    always_comb
    begin
        st_d     = st_q;
        st_d.s1  = async_i;
        st_d.s2  = st_q.s1;
        st_d.s3  = st_q.s2;
        st_d.lvl = lvl_n;
    end

    // ------------------------------------------------------------
    // per bit: change accepted once second and third stage agree
    // ------------------------------------------------------------
    for (genvar i = 0; i < WIDTH; i++)
    begin : g_bit
        assign lvl_n[i] = (st_q.s2[i] == st_q.s3[i]) ? st_q.s3[i]
                                                      : st_q.lvl[i];
    end

    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            st_q <= '0;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign level_o = st_q.lvl;

endmodule : lbm_sync

//--- lbm_tick.sv
module lbm_tick #(
    parameter int unsigned PERIOD = lbm_pkg::BUCKET_CYCLE_CLKS
) (
    input  wire logic clk_i,
    input  wire logic reset_i,
    output logic      tick_o
);
    import lbm_pkg::*;

    typedef struct packed {
        logic [31:0] cnt;
        logic        tick;
    } lbm_tick_st_t;

    lbm_tick_st_t st_q;
    lbm_tick_st_t st_d;

    always_comb
    begin
        st_d      = st_q;
        st_d.tick = 1'b0;
        if (st_q.cnt >= PERIOD - 1)
        begin
            st_d.cnt  = '0;
            st_d.tick = 1'b1;
        end
        else
        begin
            st_d.cnt = st_q.cnt + 32'h1;
        end
    end

    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            st_q <= '0;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign tick_o = st_q.tick;

endmodule : lbm_tick

//--- lbm_monitor.sv
// Behaviour
// - inputs judged once per 128 ms cycle; accumulator moves only then
// - a cycle with failure or erratic input adds one to accumulator
// - clean span length is 1, 2, 4 or 8 cycles, from decay setting
// - each fully clean span subtracts one from accumulator
// - alarm clears when accumulator falls to the lower threshold
// - accumulator clamped to bucket capacity on each cycle boundary, failures at capacity flagged
module lbm_monitor #(
    parameter int unsigned TICK_CYCLES = lbm_pkg::BUCKET_CYCLE_CLKS
) (
    input  wire logic                         clk_i,
    input  wire logic                         reset_i,
    input  wire logic                         input_fail_i,
    input  wire logic                         input_erratic_i,
    input  wire logic [lbm_pkg::ADDR_W-1:0]   address_i,
    input  wire logic                         read_i,
    input  wire logic                         write_i,
    input  wire logic [3:0]                   byteenable_i,
    input  wire logic [lbm_pkg::DATA_W-1:0]   writedata_i,
    output logic      [lbm_pkg::DATA_W-1:0]   readdata_o,
    output logic                              waitrequest_o,
    output logic                              alarm_o,
    output logic      [7:0]                   level_o,
    output logic                              irq_o
);
    import lbm_pkg::*;

    typedef struct packed {
        lbm_bus_t          bus;
        logic              wait_r;
        logic [31:0]       rdata;
        logic [7:0]        upper;
        logic [7:0]        lower;
        logic [7:0]        cap;
        logic [1:0]        decay;
        logic [ST_W-1:0]   status;
        logic [ST_W-1:0]   mask;
        logic [7:0]        acc;
        logic [3:0]        clean;
        logic              fail_seen;
        logic              alarm;
        logic              irq;
    } lbm_st_t;

    lbm_st_t     st_q;
    lbm_st_t     st_d;
    logic [1:0]  in_lvl;
    logic        tick_w;
    logic        fail_now;
    logic        fail_cyc;
    logic [3:0]  span;
    logic [7:0]  idx;

    // ------------------------------------------------------------
    // input conditioning and cycle timer
    // ------------------------------------------------------------
    lbm_sync #(
        .WIDTH (2)
    ) u_lbm_sync (
        .clk_i   (clk_i),
        .reset_i (reset_i),
        .async_i ({input_erratic_i, input_fail_i}),
        .level_o (in_lvl)
    );

    lbm_tick #(
        .PERIOD (TICK_CYCLES)
    ) u_lbm_tick (
        .clk_i   (clk_i),
        .reset_i (reset_i),
        .tick_o  (tick_w)
    );

    assign fail_now = |in_lvl;
    // a failure in the tick cycle itself still counts for that cycle
    assign fail_cyc = st_q.fail_seen | fail_now;
    assign span     = 4'h1 << st_q.decay;
    assign idx      = address_i[9:2];

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb
    begin
        logic [7:0]      acc_n;
        logic [ST_W-1:0] ev;
        logic [4:0]      clean_n;
        acc_n   = st_q.acc;
        ev      = '0;
        clean_n = {1'b0, st_q.clean} + 5'h1;
        st_d    = st_q;

        // bus slave: one wait cycle, then the answer
        case (st_q.bus)
            BUS_IDLE:
            begin
                st_d.wait_r = 1'b1;
                if (read_i || write_i)
                begin
                    st_d.bus    = BUS_ACK;
                    st_d.wait_r = 1'b0;
                    st_d.rdata  = '0;
                    if (read_i)
                    begin
                        case (idx)
                            IDX_UPPER:  st_d.rdata[7:0] = st_q.upper;
                            IDX_LOWER:  st_d.rdata[7:0] = st_q.lower;
                            IDX_CAP:    st_d.rdata[7:0] = st_q.cap;
                            IDX_DECAY:  st_d.rdata[1:0] = st_q.decay;
                            IDX_STATUS: st_d.rdata[ST_W-1:0] = st_q.status;
                            IDX_MASK:   st_d.rdata[ST_W-1:0] = st_q.mask;
                            IDX_ACC:    st_d.rdata[7:0] = st_q.acc;
                            IDX_FLAGS:  st_d.rdata[0]   = st_q.alarm;
                            default:    st_d.rdata      = '0;
                        endcase
                    end
                end
            end
            BUS_ACK:
            begin
                st_d.bus    = BUS_IDLE;
                st_d.wait_r = 1'b1;
                if (write_i && byteenable_i[0])
                begin
                    case (idx)
                        IDX_UPPER:  st_d.upper = writedata_i[7:0];
                        IDX_LOWER:  st_d.lower = writedata_i[7:0];
                        IDX_CAP:    st_d.cap   = writedata_i[7:0];
                        IDX_DECAY:  st_d.decay = writedata_i[1:0];
                        IDX_STATUS:
                            st_d.status = st_q.status
                                          & ~writedata_i[ST_W-1:0];
                        IDX_MASK:   st_d.mask  = writedata_i[ST_W-1:0];
                        default:    st_d.upper = st_q.upper;
                    endcase
                end
            end
            default:
            begin
                st_d.bus    = BUS_IDLE;
                st_d.wait_r = 1'b1;
            end
        endcase

        // leaky bucket, evaluated only on cycle boundaries
        st_d.fail_seen = tick_w ? 1'b0 : fail_cyc;
        if (tick_w)
        begin
            if (fail_cyc)
            begin
                st_d.clean = '0;
                if (st_q.acc >= st_q.cap)
                begin
                    acc_n      = st_q.cap;
                    ev[ST_SAT] = 1'b1;
                end
                else
                begin
                    acc_n = st_q.acc + 8'h1;
                end
            end
            else if (clean_n >= {1'b0, span})
            begin
                st_d.clean = '0;
                if (st_q.acc != 8'h0)
                begin
                    acc_n = st_q.acc - 8'h1;
                end
            end
            else
            begin
                st_d.clean = clean_n[3:0];
            end
            // capacity lowered by software below the fill: clamp
            if (acc_n > st_q.cap)
            begin
                acc_n = st_q.cap;
            end
            st_d.acc = acc_n;
            // clear wins if thresholds are programmed crossed
            if (acc_n <= st_q.lower)
            begin
                st_d.alarm   = 1'b0;
                ev[ST_CLEAR] = st_q.alarm;
            end
            else if (acc_n >= st_q.upper)
            begin
                st_d.alarm   = 1'b1;
                ev[ST_RAISE] = ~st_q.alarm;
            end
        end

        // sticky events: a set in the clearing cycle is kept
        st_d.status = st_d.status | ev;
        st_d.irq    = |(st_d.status & st_d.mask);
    end

    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            st_q        <= '0;
            st_q.bus    <= BUS_IDLE;
            st_q.wait_r <= 1'b1;
            st_q.upper  <= RST_UPPER;
            st_q.lower  <= RST_LOWER;
            st_q.cap    <= RST_CAP;
            st_q.decay  <= RST_DECAY;
            st_q.mask   <= RST_MASK;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign readdata_o    = st_q.rdata;
    assign waitrequest_o = st_q.wait_r;
    assign alarm_o       = st_q.alarm;
    assign level_o       = st_q.acc;
    assign irq_o         = st_q.irq;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (reset_i);

    sequence s_req_waiting;
        (read_i || write_i) && waitrequest_o;
    endsequence

    sequence s_answer;
        !waitrequest_o ##1 waitrequest_o;
    endsequence

    a_bus_answer_one:
    assert property (s_req_waiting |=> s_answer)
        else $error("bus answer not given after one wait cycle");

    a_acc_on_tick:
    assert property ($changed(st_q.acc) |-> $past(tick_w))
        else $error("accumulator moved off a cycle boundary");

    a_fill_step:
    assert property (tick_w && fail_cyc && st_q.acc < st_q.cap
                     |=> st_q.acc == $past(st_q.acc) + 8'h1)
        else $error("failure cycle did not add one");

    a_span_hold:
    assert property (tick_w && !fail_cyc
                     && ({1'b0, st_q.clean} + 5'h1) < {1'b0, span}
                     |=> $stable(st_q.acc))
        else $error("accumulator moved inside a clean span");

    a_decay_step:
    assert property (tick_w && !fail_cyc && st_q.acc != 8'h0
                     && st_q.acc <= st_q.cap
                     && ({1'b0, st_q.clean} + 5'h1) >= {1'b0, span}
                     |=> st_q.acc == $past(st_q.acc) - 8'h1)
        else $error("completed clean span did not subtract one");

    a_alarm_clear:
    assert property ($past(tick_w) && st_q.acc <= $past(st_q.lower)
                     |-> !st_q.alarm)
        else $error("alarm kept at or below lower threshold");

    a_cap_limit:
    assert property ($past(tick_w) |-> st_q.acc <= $past(st_q.cap))
        else $error("accumulator above bucket capacity");

    a_alarm_raise:
    assert property ($past(tick_w) && st_q.acc >= $past(st_q.upper)
                     && st_q.acc > $past(st_q.lower) |-> st_q.alarm)
        else $error("alarm not raised at upper threshold");

    a_alarm_hold:
    assert property (!$past(tick_w) |-> $stable(st_q.alarm))
        else $error("alarm changed between cycle boundaries");

    a_sat_flag:
    assert property (tick_w && fail_cyc && st_q.acc >= st_q.cap
                     |=> st_q.status[ST_SAT])
        else $error("failure at capacity not flagged");

    a_clear_flag:
    assert property ($fell(st_q.alarm) |-> st_q.status[ST_CLEAR])
        else $error("alarm clear not flagged");

    a_raise_flag:
    assert property ($rose(st_q.alarm) |-> st_q.status[ST_RAISE])
        else $error("alarm raise not flagged");

    a_irq_level:
    assert property (irq_o == |(st_q.status & st_q.mask))
        else $error("interrupt does not follow status and mask");

    a_read_clean:
    assert property (!waitrequest_o |-> readdata_o[31:8] == 24'h0)
        else $error("reserved read data bits not zero");

    a_wait_idle:
    assert property (!(read_i || write_i) && waitrequest_o
                     |=> waitrequest_o)
        else $error("bus answered without a request");

endmodule : lbm_monitor

//--- lbm_monitor_bench.sv
module lbm_monitor_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import lbm_pkg::*;

    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    localparam int unsigned TICKS = 20;
    logic              clk_i;
    logic              reset_i;
    logic              input_fail_i;
    logic              input_erratic_i;
    logic [ADDR_W-1:0] address_i;
    logic              read_i;
    logic              write_i;
    logic [3:0]        byteenable_i;
    logic [DATA_W-1:0] writedata_i;
    logic [DATA_W-1:0] readdata_o;
    logic              waitrequest_o;
    logic              alarm_o;
    logic [7:0]        level_o;
    logic              irq_o;
    int                mismatches;
    int                cmp_count;
    logic [31:0]       rd;
    int                n;

    lbm_monitor #(.TICK_CYCLES(TICKS)) u_lbm_monitor (
        .clk_i           (clk_i),
        .reset_i         (reset_i),
        .input_fail_i    (input_fail_i),
        .input_erratic_i (input_erratic_i),
        .address_i       (address_i),
        .read_i          (read_i),
        .write_i         (write_i),
        .byteenable_i    (byteenable_i),
        .writedata_i     (writedata_i),
        .readdata_o      (readdata_o),
        .waitrequest_o   (waitrequest_o),
        .alarm_o         (alarm_o),
        .level_o         (level_o),
        .irq_o           (irq_o)
    );

    always #12.5 clk_i = ~clk_i;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic final_report;
        if (mismatches == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : final_report

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic chk_cnt(input int got, input int exp);
        cmp_count++;
        if (got != exp)
        begin
            mismatches++;
            $display("Error at %0t: count %0d expected %0d", $time, got, exp);
        end
    endtask : chk_cnt

    // waits for the slave's answer; only the watchdog ends a hang
    task automatic bus(input logic wr, input logic [7:0] idx,
                       input logic [7:0] d, output logic [31:0] q);
        @(posedge clk_i);
        address_i   <= {idx, 2'b00};
        writedata_i <= {24'h0, d};
        read_i      <= ~wr;
        write_i     <= wr;
        // pre-edge values: what the slave showed at this edge
        do @(posedge clk_i); while (waitrequest_o !== 1'b0);
        q = readdata_o;
        read_i  <= 1'b0;
        write_i <= 1'b0;
    endtask : bus

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, idx, d, q);
    endtask : wr

    // clocks until level_o moves; bounded so a stuck counter shows
    task automatic wait_chg(output int c);
        logic [7:0] p;
        p = level_o;
        c = 0;
        do
        begin
            @(negedge clk_i);
            c++;
        end
        while (level_o === p && c < 400);
        if (c >= 400)
            chk_cnt(c, 0);
    endtask : wait_chg

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        chk({alarm_o, irq_o, level_o}, 32'h0);
        bus(1'b0, IDX_LOWER, 8'h00, rd); chk(rd, 32'h04);
        bus(1'b0, IDX_CAP, 8'h00, rd);   chk(rd, 32'h08);
        bus(1'b0, IDX_DECAY, 8'h00, rd); chk(rd, 32'h01);
        @(posedge clk_i) byteenable_i <= 4'hE;
        wr(IDX_CAP, 8'h55);
        byteenable_i <= 4'hF;
        bus(1'b0, IDX_CAP, 8'h00, rd);   chk(rd, 32'h08);
        wr(8'h70, 8'hA5);
        bus(1'b0, 8'h70, 8'h00, rd);     chk(rd, 32'h00);
        wr(IDX_DECAY, 8'hFF);
        bus(1'b0, IDX_DECAY, 8'h00, rd); chk(rd, 32'h03);
    endtask : t_reset

    task automatic t_fill;
        wr(IDX_UPPER, 8'h02);
        wr(IDX_LOWER, 8'h01);
        wr(IDX_CAP, 8'h03);
        wr(IDX_DECAY, 8'h00);
        wr(IDX_MASK, 8'h07);
        bus(1'b0, IDX_LOWER, 8'h00, rd); chk(rd, 32'h01);
        @(posedge clk_i) input_erratic_i <= 1'b1;
        wait_chg(n);
        chk(level_o, 8'h01);
        chk(alarm_o, 1'b0);
        wait_chg(n);
        chk_cnt(n, TICKS);
        chk({alarm_o, level_o}, {1'b1, 8'h02});
        @(posedge clk_i);
        input_erratic_i <= 1'b0;
        input_fail_i    <= 1'b1;
        wait_chg(n);
        chk(level_o, 8'h03);
        repeat (3 * TICKS) @(negedge clk_i);
        chk(level_o, 8'h03);
        bus(1'b0, IDX_ACC, 8'h00, rd);   chk(rd, 32'h03);
        bus(1'b0, IDX_STATUS, 8'h00, rd); chk(rd, 32'h05);
        bus(1'b0, IDX_FLAGS, 8'h00, rd); chk(rd, 32'h01);
        chk(irq_o, 1'b1);
    endtask : t_fill

    task automatic t_decay;
        @(posedge clk_i) input_fail_i <= 1'b0;
        wait_chg(n);
        chk({alarm_o, level_o}, {1'b1, 8'h02});
        wait_chg(n);
        chk_cnt(n, TICKS);
        chk({alarm_o, level_o}, {1'b0, 8'h01});
        bus(1'b0, IDX_STATUS, 8'h00, rd); chk(rd, 32'h07);
        wr(IDX_STATUS, 8'h07);
        bus(1'b0, IDX_STATUS, 8'h00, rd); chk(rd, 32'h00);
        chk(irq_o, 1'b0);
    endtask : t_decay

    task automatic t_rates;
        for (int r = 1; r < 4; r++)
        begin
            wr(IDX_DECAY, r[7:0]);
            @(posedge clk_i) input_fail_i <= 1'b1;
            do wait_chg(n); while (level_o !== 8'h03 && n < 400);
            @(posedge clk_i) input_fail_i <= 1'b0;
            wait_chg(n);
            chk(level_o, 8'h02);
            wait_chg(n);
            chk_cnt(n, TICKS << r);
            chk({alarm_o, level_o}, {1'b0, 8'h01});
        end
    endtask : t_rates

    task automatic t_irq;
        wr(IDX_MASK, 8'h00);
        @(negedge clk_i);
        chk(irq_o, 1'b0);
        bus(1'b0, IDX_STATUS, 8'h00, rd); chk(rd, 32'h07);
        wr(IDX_MASK, 8'h02);
        @(negedge clk_i);
        chk(irq_o, 1'b1);
        wr(IDX_STATUS, 8'h02);
        @(negedge clk_i);
        chk(irq_o, 1'b0);
        bus(1'b0, IDX_STATUS, 8'h00, rd); chk(rd, 32'h05);
    endtask : t_irq

    // reset in mid-run brings every register back to its default
    task automatic t_rst_mid;
        wr(IDX_UPPER, 8'h09);
        wr(IDX_MASK, 8'h07);
        @(posedge clk_i) reset_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        reset_i <= 1'b0;
        @(negedge clk_i);
        chk({alarm_o, irq_o, level_o}, 32'h0);
        bus(1'b0, IDX_UPPER, 8'h00, rd);  chk(rd, 32'h06);
        bus(1'b0, IDX_MASK, 8'h00, rd);   chk(rd, 32'h00);
        bus(1'b0, IDX_STATUS, 8'h00, rd); chk(rd, 32'h00);
        bus(1'b0, IDX_ACC, 8'h00, rd);    chk(rd, 32'h00);
        bus(1'b0, IDX_FLAGS, 8'h00, rd);  chk(rd, 32'h00);
    endtask : t_rst_mid

    // ------------------------------------------------------------
    // sequence and watchdog
    // ------------------------------------------------------------
    initial
    begin
        clk_i           = 1'b0;
        reset_i         = 1'b1;
        input_fail_i    = 1'b0;
        input_erratic_i = 1'b0;
        address_i       = '0;
        read_i          = 1'b0;
        write_i         = 1'b0;
        byteenable_i    = 4'hF;
        writedata_i     = '0;
        mismatches      = 0;
        cmp_count       = 0;
        repeat (8) @(posedge clk_i);
        reset_i <= 1'b0;
        @(negedge clk_i);
        t_reset();
        t_fill();
        t_decay();
        t_rates();
        t_irq();
        t_rst_mid();
        final_report();
    end

    // whole run is about a thousand clocks; twenty times that is a hang
    initial
    begin
        repeat (20000) @(posedge clk_i);
        mismatches++;
        final_report();
    end
endmodule : lbm_monitor_bench
